// file: rtl/adc_accum_defines.svh
// Constants for the conversion-control and accumulation block.
// Assumes inclusion by bare name from rtl/ and testbench/ sources.
`ifndef ADC_ACCUM_DEFINES_SVH
`define ADC_ACCUM_DEFINES_SVH

// Sample-count code limits
`define CODE_MAX          4'hA
`define CODE_ADJ_CAP      4'h0004
`define CODE_AUTO_BASE    4'h0004
// Resolution codes (12-bit after reset)
`define RES_12            2'h0
`define RES_16            2'h1
`define RES_10            2'h2
`define RES_8             2'h3
`define RES_RESET         2'h0
// Ground selection codes for the negative input
`define GND_INTERNAL      2'h0
`define GND_IO            2'h1
`define GND_PIN           2'h2
// Conversion timing in prescaled conversion-clock periods
`define CONV_BASE_PERIODS 5'h06
`define SAMPLE_HALF       1'b1

`endif

// file: rtl/adc_accum_pkg.sv
// Types shared by the conversion-control block.
// Assumes the defines header is compiled alongside.
package adc_accum_pkg;
  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0001,
    ST_SAMPLE = 4'b0010,
    ST_CONV   = 4'b0100,
    ST_DONE   = 4'b1000
  } conv_state_t;
endpackage

// file: rtl/conv_link_if.sv
// Carries one finished raw conversion from the sequencer to the datapath.
// Assumes a single clock domain.
`timescale 1ns/1ns
`default_nettype none
interface conv_link_if;
  logic        done;   // One-cycle pulse per finished conversion
  logic [11:0] data;   // Raw conversion value
  logic        first;  // Conversion opens a new sequence
  modport seq (output done, output data, output first);
  modport dp  (input done, input data, input first);
endinterface
`default_nettype wire

// file: rtl/adc_accum_datapath.sv
// Accumulation and averaging datapath.
// Assumes an asynchronous active-high reset shared with the top.
`timescale 1ns/1ns
`default_nettype none
`include "adc_accum_defines.svh"
module adc_accum_datapath (
  input  wire logic        clk,
  input  wire logic        rst,
  conv_link_if.dp          link,
  input  wire logic [3:0]  sample_count_code,
  input  wire logic [2:0]  adjust_shift,
  input  wire logic        average_en,
  output logic             result_done,
  output logic [15:0]      result_value
);
  // ****************************************
  // Shift arithmetic
  // ****************************************
  function automatic logic [3:0] code_eff(input logic [3:0] c);
    code_eff = (c > `CODE_MAX) ? 4'h0 : c;
  endfunction

  logic [21:0] acc_q, acc_d;
  logic [10:0] cnt_q, cnt_d;
  logic        done_q, done_d;
  logic [15:0] res_q, res_d;
  logic [3:0]  code;
  logic [3:0]  auto_sh;
  logic [3:0]  adj_sh;
  logic [21:0] sum;
  logic [10:0] need;

  // Next sum, count and result
  always_comb begin
    code    = code_eff(sample_count_code);
    auto_sh = (code > `CODE_AUTO_BASE) ? code - `CODE_AUTO_BASE : 4'h0;
    // Averaging adds the adjust shift, capped so totals stop at ten
    adj_sh  = (!average_en || code == 4'h0) ? 4'h0 :
              ({1'b0, adjust_shift} > `CODE_ADJ_CAP) ? `CODE_ADJ_CAP : {1'b0, adjust_shift};
    need    = 11'(11'h001 << code);
    sum     = (link.first ? 22'h0 : acc_q) + {10'h0, link.data};
    acc_d   = acc_q;
    cnt_d   = cnt_q;
    done_d  = 1'b0;
    res_d   = res_q;
    if (link.done) begin
      acc_d = sum;
      cnt_d = link.first ? 11'h001 : 11'(cnt_q + 11'h001);
      if (cnt_d >= need) begin
        res_d  = 16'((sum >> auto_sh) >> adj_sh);
        done_d = 1'b1;
        acc_d  = 22'h0;
        cnt_d  = 11'h000;
      end
    end
  end

  // Registers only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      acc_q  <= 22'h0;
      cnt_q  <= 11'h000;
      done_q <= 1'b0;
      res_q  <= 16'h0000;
    end else begin
      acc_q  <= acc_d;
      cnt_q  <= cnt_d;
      done_q <= done_d;
      res_q  <= res_d;
    end
  end

  assign result_done  = done_q;
  assign result_value = res_q;
endmodule
`default_nettype wire

// file: rtl/adc_accumulate_average_control.sv
// Conversion sequencing, start synchronisation, sampling and result flagging.
// Assumes the analog core answers each conversion request with core_valid
// carrying a 12-bit value; prescaled clock arrives as a one-cycle tick.
`timescale 1ns/1ns
`default_nettype none
`include "adc_accum_defines.svh"
module adc_accumulate_average_control #(
  parameter int unsigned SAMPLE_LEN_W = 6
) (
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire logic                    enable,
  input  wire logic                    diff_select,
  input  wire logic                    free_run,
  input  wire logic [1:0]              resolution_select,
  input  wire logic [1:0]              ground_select,
  input  wire logic [SAMPLE_LEN_W-1:0] sample_length,
  input  wire logic [3:0]              sample_count_code,
  input  wire logic [2:0]              adjust_shift,
  input  wire logic                    average_en,
  input  wire logic                    sw_start,
  input  wire logic                    event_start,
  input  wire logic                    event_start_en,
  input  wire logic                    result_ready_clear,
  input  wire logic                    conv_tick,
  input  wire logic                    core_valid,
  input  wire logic [11:0]             core_data,
  output logic                         core_sample,
  output logic                         core_convert,
  output logic                         core_diff,
  output logic [1:0]                   core_resolution,
  output logic [1:0]                   core_ground,
  output logic                         result_ready_flag,
  output logic [15:0]                  result_value,
  output logic                         busy
);
  // ****************************************
  // Start synchroniser
  // ****************************************
  logic [1:0] start_sync_q, start_sync_d;
  logic       start_req;

  // Two flops before use; only the second is looked at
  always_comb begin
    start_sync_d = {start_sync_q[0], sw_start | (event_start & event_start_en)};
    start_req    = start_sync_q[1];
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      start_sync_q <= 2'b00;
    end else begin
      start_sync_q <= start_sync_d;
    end
  end

  // ****************************************
  // Conversion sequencer
  // ****************************************
  adc_accum_pkg::conv_state_t st_q, st_d;
  logic [SAMPLE_LEN_W:0]      samp_q, samp_d;
  logic                       first_q, first_d;
  logic                       pend_q, pend_d;
  logic                       samp_o_q, samp_o_d;
  logic                       conv_o_q, conv_o_d;
  logic [11:0]                data_q, data_d;
  logic                       ldone_q, ldone_d;
  logic                       lfirst_q, lfirst_d;
  logic                       busy_q, busy_d;
  logic                       dp_done;       // Datapath closed a sequence

  // Sampling counts half periods: one half by default, plus two per step
  always_comb begin
    st_d     = st_q;
    samp_d   = samp_q;
    first_d  = first_q;
    pend_d   = pend_q | start_req;
    samp_o_d = 1'b0;
    conv_o_d = 1'b0;
    data_d   = data_q;
    ldone_d  = 1'b0;
    lfirst_d = lfirst_q;
    case (st_q)
      adc_accum_pkg::ST_IDLE: begin
        if (enable && pend_q) begin
          pend_d = 1'b0;
          st_d   = adc_accum_pkg::ST_SAMPLE;
          samp_d = {sample_length, `SAMPLE_HALF};
          first_d = 1'b1;
        end
      end
      adc_accum_pkg::ST_SAMPLE: begin
        samp_o_d = 1'b1;
        if (conv_tick) begin
          if (samp_q <= (SAMPLE_LEN_W+1)'(1)) begin
            st_d = adc_accum_pkg::ST_CONV;
          end else begin
            samp_d = (SAMPLE_LEN_W+1)'(samp_q - (SAMPLE_LEN_W+1)'(1));
          end
        end
      end
      adc_accum_pkg::ST_CONV: begin
        conv_o_d = 1'b1;
        if (core_valid) begin
          data_d   = core_data;
          ldone_d  = 1'b1;
          lfirst_d = first_q;
          first_d  = 1'b0;
          st_d     = adc_accum_pkg::ST_DONE;
        end
      end
      adc_accum_pkg::ST_DONE: begin
        // One cycle of wait lets the datapath say whether the run closed,
        // otherwise a finished run would start one conversion too many
        if (!ldone_q) begin
          if (free_run || !dp_done) begin
            st_d   = adc_accum_pkg::ST_SAMPLE;
            samp_d = {sample_length, `SAMPLE_HALF};
            if (dp_done) begin
              first_d = 1'b1;
            end
          end else begin
            st_d = adc_accum_pkg::ST_IDLE;
          end
        end
      end
      default: begin
        st_d = adc_accum_pkg::ST_IDLE;
      end
    endcase
    if (!enable) begin
      st_d = adc_accum_pkg::ST_IDLE;
    end
    busy_d = samp_o_d | conv_o_d;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q      <= adc_accum_pkg::ST_IDLE;
      samp_q    <= '0;
      first_q   <= 1'b1;
      pend_q    <= 1'b0;
      samp_o_q  <= 1'b0;
      conv_o_q  <= 1'b0;
      data_q    <= 12'h000;
      ldone_q   <= 1'b0;
      lfirst_q  <= 1'b0;
      busy_q    <= 1'b0;
    end else begin
      st_q      <= st_d;
      samp_q    <= samp_d;
      first_q   <= first_d;
      pend_q    <= pend_d;
      samp_o_q  <= samp_o_d;
      conv_o_q  <= conv_o_d;
      data_q    <= data_d;
      ldone_q   <= ldone_d;
      lfirst_q  <= lfirst_d;
      busy_q    <= busy_d;
    end
  end

  // ****************************************
  // Datapath and result flag
  // ****************************************
  conv_link_if link ();
  assign link.done  = ldone_q;
  assign link.data  = data_q;
  assign link.first = lfirst_q;

  logic [15:0] dp_value;
  adc_accum_datapath u_dp (
    .clk               (clk),
    .rst               (rst),
    .link              (link),
    .sample_count_code (sample_count_code),
    .adjust_shift      (adjust_shift),
    .average_en        (average_en),
    .result_done       (dp_done),
    .result_value      (dp_value)
  );

  logic        flag_q, flag_d;
  logic [15:0] res_q, res_d;
  logic        diff_q;
  logic [1:0]  resv_q, gnd_q;

  // Set beats clear so a result landing on a clear is never lost
  always_comb begin
    flag_d = dp_done ? 1'b1 : (result_ready_clear ? 1'b0 : flag_q);
    res_d  = dp_done ? dp_value : res_q;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flag_q <= 1'b0;
      res_q  <= 16'h0000;
      diff_q <= 1'b0;
      resv_q <= `RES_RESET;
      gnd_q  <= `GND_INTERNAL;
    end else begin
      flag_q <= flag_d;
      res_q  <= res_d;
      diff_q <= diff_select;
      resv_q <= resolution_select;
      gnd_q  <= ground_select;
    end
  end
  assign core_sample       = samp_o_q;
  assign core_convert      = conv_o_q;
  assign core_diff         = diff_q;
  assign core_resolution   = resv_q;
  assign core_ground       = gnd_q;
  assign result_ready_flag = flag_q;
  assign result_value      = res_q;
  assign busy              = busy_q;
endmodule
`default_nettype wire

// file: testbench/adc_core_model.sv
// Behavioural analog core: conversion ticks and answers.
// Assumes core_convert stays high until core_valid.
`timescale 1ns/1ns
`default_nettype none
module adc_core_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        core_convert,
  input  wire logic [3:0]  delay,
  input  wire logic [11:0] value,
  output logic             conv_tick,
  output logic             core_valid,
  output logic [11:0]      core_data
);
  // ******
  // Core
  // ******
  logic [3:0] cnt_q;
  // Tick every other cycle; answer after delay+1 cycles of converting
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      {conv_tick, core_valid, cnt_q} <= '0;
    end else begin
      conv_tick <= ~conv_tick;
      core_valid <= core_convert && !core_valid && cnt_q == delay;
      cnt_q <= (core_convert && !core_valid && cnt_q != delay) ? cnt_q + 4'h1 : 4'h0;
    end
  end
  // Moving pattern outside valid, so stale data never looks right
  assign core_data = core_valid ? value : ~value ^ {8'h00, cnt_q};
endmodule
`default_nettype wire

// file: testbench/adc_accum_monitor.sv
// Checker for the conversion-control block.
// Assumes one clock and the async high reset.
`timescale 1ns/1ns
`default_nettype none
module adc_accum_monitor #(
  parameter int unsigned SAMPLE_LEN_W = 6
) (
  input wire logic                    clk,
  input wire logic                    rst,
  input wire logic                    diff_select,
  input wire logic                    free_run,
  input wire logic [SAMPLE_LEN_W-1:0] sample_length,
  input wire logic [3:0]              sample_count_code,
  input wire logic                    conv_tick,
  input wire logic                    core_valid,
  input wire logic                    core_sample,
  input wire logic                    core_convert,
  input wire logic                    core_diff,
  input wire logic                    result_ready_flag,
  input wire logic [15:0]             result_value,
  input wire logic                    busy
);
  // ******
  // Rules
  // ******
  logic [7:0] tick_q;
  logic [7:0] tick_d;
  logic       tick_late_q;
  // Ticks seen while sampling; the tick is delayed one cycle because
  // core_sample is registered one cycle behind the sequencer's own count
  always_comb tick_d = core_sample ? 8'(tick_q + 8'(tick_late_q)) : 8'h00;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tick_q      <= 8'h00;
      tick_late_q <= 1'b0;
    end else begin
      tick_q      <= tick_d;
      tick_late_q <= conv_tick;
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  diff_follow_a: assert property (
    !$past(rst) |-> core_diff == $past(diff_select)) else $error("diff mode lags");
  sample_first_a: assert property (
    $rose(core_convert) |-> $past(core_sample)) else $error("convert without sampling");
  sample_len_a: assert property (
    $fell(core_sample) |-> tick_q == 8'(2 * sample_length + 1)) else $error("sampling length");
  flag_source_a: assert property (
    $rose(result_ready_flag) |-> $past(core_valid, 3)) else $error("flag without closing");
  flag_each_a: assert property (
    core_valid && sample_count_code == 4'h0 |-> ##3 result_ready_flag) else $error("flag missed");
  result_write_a: assert property (
    !$stable(result_value) |-> result_ready_flag) else $error("result without flag");
  free_restart_a: assert property (
    core_valid && free_run ##1 free_run [*4] |-> ##[0:40] core_sample) else $error("no restart");
  busy_cover_a: assert property (
    core_sample || core_convert |-> busy) else $error("active while idle");
endmodule
bind adc_accumulate_average_control adc_accum_monitor #(.SAMPLE_LEN_W(SAMPLE_LEN_W)) mon (
  .clk, .rst, .diff_select, .free_run, .sample_length, .sample_count_code, .conv_tick,
  .core_valid, .core_sample, .core_convert, .core_diff, .result_ready_flag, .result_value, .busy);
`default_nettype wire

// file: testbench/adc_accumulate_average_control_test.sv
// Self-checking bench: random runs over every sample-count code.
// Assumes the core model and the checker are compiled first.
`timescale 1ns/1ns
`default_nettype none
`include "adc_accum_defines.svh"
module adc_accumulate_average_control_test;
  // ******
  // Bench
  // ******
  logic        clk, rst, enable, diff_select, free_run, average_en;
  logic        sw_start, event_start, event_start_en, result_ready_clear;
  logic        conv_tick, core_valid, core_sample, core_convert, core_diff;
  logic        result_ready_flag, busy;
  logic [1:0]  resolution_select, ground_select, core_resolution, core_ground;
  logic [5:0]  sample_length;
  logic [3:0]  sample_count_code, delay;
  logic [2:0]  adjust_shift;
  logic [11:0] value, core_data;
  logic [15:0] result_value;
  int          mismatches, comparisons, valids;

  adc_accumulate_average_control dut (
    .clk, .rst, .enable, .diff_select, .free_run, .resolution_select, .ground_select,
    .sample_length, .sample_count_code, .adjust_shift, .average_en, .sw_start, .event_start,
    .event_start_en, .result_ready_clear, .conv_tick, .core_valid, .core_data, .core_sample,
    .core_convert, .core_diff, .core_resolution, .core_ground, .result_ready_flag,
    .result_value, .busy);
  adc_core_model core (.clk, .rst, .core_convert, .delay, .value, .conv_tick, .core_valid, .core_data);

  // 50 MHz clock and a count of answered conversions
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) if (core_valid === 1'b1) valids++;

  // Sum, automatic shift, then capped adjust shift; reserved codes act as one sample
  function automatic logic [15:0] expect_avg(logic [3:0] c, logic [2:0] a, logic avg, logic [11:0] v);
    logic [3:0]  n;
    logic [21:0] s;
    n = (c > 4'hA) ? 4'h0 : c;
    s = (22'(v) << n) >> ((n > 4'h4) ? n - 4'h4 : 4'h0);
    if (avg && n != 4'h0) s = s >> ((a > 3'h4) ? 3'h4 : a);
    return s[15:0];
  endfunction

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic pulse_start(input logic ev);
    sw_start = !ev;
    event_start = ev;
    @(negedge clk);
    sw_start = 1'b0;
    event_start = 1'b0;
  endtask

  task automatic wait_flag;
    for (int i = 0; i < 40000 && result_ready_flag !== 1'b1; i++) @(negedge clk);
    if (result_ready_flag !== 1'b1) mismatches++;
  endtask

  // A block that never goes idle counts as a mismatch
  task automatic wait_idle;
    for (int i = 0; i < 200 && busy !== 1'b0; i++) @(negedge clk);
    if (busy !== 1'b0) mismatches++;
  endtask

  task automatic clear_flag;
    result_ready_clear = 1'b1;
    @(negedge clk);
    result_ready_clear = 1'b0;
  endtask

  // One sequence; bounded waits keep a hang from stalling the run
  task automatic run(input logic [3:0] code, input logic ev, input logic [11:0] v);
    int base;
    @(negedge clk);
    sample_count_code = code;
    adjust_shift = 3'($urandom_range(7));
    average_en = 1'($urandom);
    value = v;
    delay = 4'($urandom_range(9, 2));
    sample_length = 6'($urandom_range(2));
    diff_select = 1'($urandom);
    ground_select = 2'($urandom_range(2));
    resolution_select = (code == 4'h0) ? `RES_12 : `RES_16;
    base = valids;
    pulse_start(ev);
    wait_flag;
    cmp(result_value, expect_avg(code, adjust_shift, average_en, v));
    cmp(16'(valids - base), (code > 4'hA) ? 16'h0001 : 16'h0001 << code);
    cmp(16'(core_diff), 16'(diff_select));
    cmp(16'(core_ground), 16'(ground_select));
    cmp(16'(core_resolution), 16'(resolution_select));
    clear_flag;
    wait_idle;
  endtask

  // Free-running in both conversion types; flag each conversion
  task automatic free_runs;
    for (int d = 0; d < 2; d++) begin
      @(negedge clk);
      free_run = 1'b1;
      diff_select = 1'(d);
      {sample_count_code, average_en} = '0;
      value = 12'($urandom);
      pulse_start(1'b0);
      repeat (4) begin
        wait_flag;
        cmp(result_value, 16'(value));
        clear_flag;
      end
      free_run = 1'b0;
      wait_idle;
      repeat (4) @(negedge clk);
      clear_flag;
    end
  endtask

  initial begin
    void'($urandom(76));
    {enable, diff_select, free_run, average_en, sw_start, event_start, result_ready_clear} = '0;
    {resolution_select, ground_select, sample_length, sample_count_code, adjust_shift} = '0;
    {mismatches, comparisons} = '0;
    event_start_en = 1'b1;
    value = 12'h0000;
    delay = 4'h3;
    rst = 1'b1;
    repeat (6) @(negedge clk);
    rst = 1'b0;
    enable = 1'b1;
    cmp(16'(core_resolution), 16'(`RES_RESET));
    run(4'h4, 1'b0, 12'hFFF);
    for (int c = 0; c < 16; c++) run(4'(c), 1'(c), 12'($urandom));
    event_start_en = 1'b0;
    pulse_start(1'b1);
    repeat (8) @(negedge clk);
    cmp(16'(busy), 16'h0000);
    event_start_en = 1'b1;
    free_runs();
    report_and_stop;
  end

  // Watchdog well beyond the longest expected run
  initial begin
    #1600us;
    mismatches++;
    report_and_stop;
  end
endmodule
`default_nettype wire
